// [verif/rdh_props.sv]
`timescale 1ns/1ps
`default_nettype none
// watches the pins and status outputs of the handshake block
module rdh_props (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // inputs
  input wire logic       severeErr,
  input wire logic       minorErr,
  input wire logic       warnErr,
  input wire logic       estopIn,
  input wire logic       stopReq,
  input wire logic [7:0] handIn,
  input wire logic [7:0] zoneHit,
  // outputs
  input wire logic       severe_error_flag,
  input wire logic       minor_error_flag,
  input wire logic       warning_flag,
  input wire logic       estop_active_flag,
  input wire logic       servoPowerOn,
  input wire logic       slotRunning,
  input wire logic       gpOutClear,
  input wire logic [7:0] gripper_input_state,
  input wire logic       zone_presence_flag,
  input wire logic       program_rewind_req,
  input wire logic       motionLockActive
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // stop held past the three-flop path
  sequence s_estop; estopIn[*4]; endsequence
  property p_sev; 1 |=> severe_error_flag == $past(severeErr); endproperty
  a_sev: assert property (p_sev) else $error("severe flag");
  property p_min; 1 |=> minor_error_flag == $past(minorErr); endproperty
  a_min: assert property (p_min) else $error("minor flag");
  property p_warn; 1 |=> warning_flag == $past(warnErr); endproperty
  a_warn: assert property (p_warn) else $error("warn flag");
  property p_estop; s_estop |=> estop_active_flag; endproperty
  a_estop: assert property (p_estop) else $error("estop flag");
  property p_servo; s_estop |=> !servoPowerOn; endproperty
  a_servo: assert property (p_servo) else $error("servo on");
  property p_slot; stopReq[*4] |=> !slotRunning; endproperty
  a_slot: assert property (p_slot) else $error("slot run");
  property p_hand; 1 |-> gripper_input_state == $past(handIn, 3); endproperty
  a_hand: assert property (p_hand) else $error("hand state");
  property p_zone;
    $stable(zoneHit)[*4] |=> zone_presence_flag == |$past(zoneHit);
  endproperty
  a_zone: assert property (p_zone) else $error("zone flag");
  property p_clr; gpOutClear |=> !gpOutClear; endproperty
  a_clr: assert property (p_clr) else $error("clear pulse");
  property p_lock; !program_rewind_req |-> !motionLockActive; endproperty
  a_lock: assert property (p_lock) else $error("lock gate");
endmodule
`default_nettype wire

// [verif/rdh_seq_model.sv]
`timescale 1ns/1ps
`default_nettype none
// sequencer side: drives one request pin as a held level
module rdh_seq_model (
  input wire logic clk_sys,
  output var logic pin
);
  initial pin = 1'b0;
  task pulse(input int n);
    @(posedge clk_sys) pin <= 1'b1;
    repeat (n) @(posedge clk_sys);
    pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/tb_rdh_handshake.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_rdh_handshake;
  logic clk_sys = 0, nrst = 0, regWr = 0, regRd = 0, slot_run_req = 0;
  logic slot_halt_req = 0, stopReq = 0, estopIn = 0, motion_lock_req = 0;
  logic warmup_mode_enable = 0, batteryLow = 0, severeErr = 0;
  logic minorErr = 0, warnErr = 0, warmupRun = 0;
  logic [7:0] regAddr = 0, handIn = 0, zoneHit = 0;
  logic [31:0] regWdata = 0;
  wire logic retreat_return_req, gp_output_clear_req, irqOut, retreatActive;
  wire logic gpOutClear, battery_low_flag, severe_error_flag, warning_flag;
  wire logic minor_error_flag, estop_active_flag, slotRunning, servoPowerOn;
  wire logic zone_presence_flag, warmup_active_flag, program_rewind_req;
  wire logic motionLockActive;
  wire logic [7:0] gripper_input_state;
  wire logic [31:0] regRdata;
  int errors = 0, tests_run = 0, n;
  // status rows: {batt,severe,minor,warn}, hand, zones
  logic [19:0] rows [4] = '{20'hA_5A01, 20'h5_A580, 20'hF_FF00, 20'h0_0000};
  always #10 clk_sys = ~clk_sys;
  rdh_handshake #(.QUAL_CYC(8)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqOut(irqOut),
    .retreat_return_req(retreat_return_req),
    .gp_output_clear_req(gp_output_clear_req),
    .slot_run_req(slot_run_req), .slot_halt_req(slot_halt_req),
    .stopReq(stopReq), .estopIn(estopIn), .motion_lock_req(motion_lock_req),
    .warmup_mode_enable(warmup_mode_enable), .batteryLow(batteryLow),
    .severeErr(severeErr), .minorErr(minorErr), .warnErr(warnErr),
    .handIn(handIn), .zoneHit(zoneHit), .warmupRun(warmupRun),
    .retreatActive(retreatActive), .gpOutClear(gpOutClear),
    .battery_low_flag(battery_low_flag),
    .severe_error_flag(severe_error_flag),
    .minor_error_flag(minor_error_flag), .warning_flag(warning_flag),
    .estop_active_flag(estop_active_flag), .slotRunning(slotRunning),
    .gripper_input_state(gripper_input_state),
    .zone_presence_flag(zone_presence_flag),
    .warmup_active_flag(warmup_active_flag),
    .program_rewind_req(program_rewind_req),
    .motionLockActive(motionLockActive), .servoPowerOn(servoPowerOn));
  rdh_seq_model i_ret (.clk_sys, .pin(retreat_return_req));
  rdh_seq_model i_clr (.clk_sys, .pin(gp_output_clear_req));
  task chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int k); repeat (k) @(posedge clk_sys); #1; endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) {regAddr, regWdata, regWr} <= {a, d, 1'b1};
    @(posedge clk_sys) regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys) {regAddr, regRd} <= {a, 1'b1};
    @(posedge clk_sys) regRd <= 1'b0;
    #1 chk("rdata", regRdata, e);
  endtask
  task finish_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #400000;
    errors++;
    finish_test;
  end
  initial begin
    cyc(16);
    @(posedge clk_sys) nrst <= 1'b1;
    cyc(1);
    chk("rst", {servoPowerOn, retreatActive, slotRunning}, 0);
    cyc(4);
    chk("servo", servoPowerOn, 1);
    foreach (rows[i]) begin
      @(posedge clk_sys)
        {batteryLow, severeErr, minorErr, warnErr, handIn, zoneHit} <= rows[i];
      cyc(6);
      chk("flags", {battery_low_flag, severe_error_flag, minor_error_flag,
        warning_flag}, rows[i][19:16]);
      chk("hand", gripper_input_state, rows[i][15:8]);
      chk("zone", zone_presence_flag, |rows[i][7:0]);
      rd(8'h10, rows[i][7:0]);
    end
    rd(8'h0C, 0);
    rd(8'h14, 0);
    wr(8'h08, 32'h0000_000F);
    // short clear request must be dropped
    i_clr.pulse(4);
    cyc(16);
    rd(8'h08, 0);
    fork
      i_clr.pulse(20);
      begin
        n = 0;
        repeat (30) begin cyc(1); n += gpOutClear; end
      end
    join
    chk("gpclr", n, 1);
    wr(8'h0C, 32'h0000_0001);
    i_ret.pulse(20);
    cyc(1);
    chk("ret", {retreatActive, irqOut}, 3);
    wr(8'h00, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    cyc(2);
    chk("retdone", {retreatActive, irqOut}, 0);
    // each stop kind ends a run
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys) slot_run_req <= 1'b1;
      cyc(16);
      @(posedge clk_sys) slot_run_req <= 1'b0;
      cyc(2);
      chk("run", slotRunning, 1);
      @(posedge clk_sys) {estopIn, stopReq, slot_halt_req} <= 3'b001 << k;
      cyc(6);
      chk("stop", slotRunning, 0);
      if (k == 2) chk("estop", {estop_active_flag, servoPowerOn}, 2);
      @(posedge clk_sys) {estopIn, stopReq, slot_halt_req} <= 0;
      cyc(6);
    end
    chk("estopoff", estop_active_flag, 0);
    rd(8'h08, 32'h0000_0006);
    @(posedge clk_sys) motion_lock_req <= 1'b1;
    cyc(20);
    chk("lock", motionLockActive, 0);
    wr(8'h00, 32'h0000_0004);
    cyc(20);
    chk("lockon", {program_rewind_req, motionLockActive}, 3);
    rd(8'h00, 32'h0000_0004);
    rd(8'h04, 32'h0000_0101);
    @(posedge clk_sys) {warmup_mode_enable, warmupRun} <= 2'b11;
    cyc(20);
    chk("warm", warmup_active_flag, 1);
    wr(8'h00, 32'h0000_0006);
    cyc(4);
    chk("warmcancel", warmup_active_flag, 0);
    // mid-run reset drops every held state
    @(posedge clk_sys) nrst <= 1'b0;
    cyc(2);
    chk("rst2", {program_rewind_req, motionLockActive, servoPowerOn}, 0);
    @(posedge clk_sys) nrst <= 1'b1;
    cyc(1);
    chk("rst2off", {servoPowerOn, program_rewind_req}, 0);
    cyc(4);
    chk("rst2on", servoPowerOn, 1);
    finish_test;
  end
endmodule
bind rdh_handshake rdh_props i_props (
  .clk_sys(clk_sys), .nrst(nrst), .severeErr(severeErr),
  .minorErr(minorErr), .warnErr(warnErr), .estopIn(estopIn),
  .stopReq(stopReq), .handIn(handIn), .zoneHit(zoneHit),
  .severe_error_flag(severe_error_flag),
  .minor_error_flag(minor_error_flag), .warning_flag(warning_flag),
  .estop_active_flag(estop_active_flag), .servoPowerOn(servoPowerOn),
  .slotRunning(slotRunning), .gpOutClear(gpOutClear),
  .gripper_input_state(gripper_input_state),
  .zone_presence_flag(zone_presence_flag),
  .program_rewind_req(program_rewind_req),
  .motionLockActive(motionLockActive));
`default_nettype wire

// [verilog/rdh_defs.vh]
`ifndef RDH_DEFS_VH
`define RDH_DEFS_VH
// register byte offsets on the software port
`define RDH_ADDR_CTRL     8'h00
`define RDH_ADDR_STATUS   8'h04
`define RDH_ADDR_IRQ_STAT 8'h08
`define RDH_ADDR_IRQ_MASK 8'h0C
`define RDH_ADDR_ZONE     8'h10
// control register fields
`define RDH_CTRL_RETDONE  0
`define RDH_CTRL_WUCANCEL 1
`define RDH_CTRL_REWIND   2
// event bit positions
`define RDH_EV_RETREAT    0
`define RDH_EV_GPCLR      1
`define RDH_EV_ESTOP      2
`define RDH_EV_SEVERE     3
// reset values
`define RDH_MASK_RST      4'h0
// timing
`define RDH_CLK_HZ        50000000
`define RDH_QUAL_MS       30
`define RDH_QUAL_CYC      ((`RDH_CLK_HZ / 1000) * `RDH_QUAL_MS)
`endif

// [verilog/rdh_handshake.v]
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "rdh_defs.vh"
module rdh_handshake #(
  parameter QUAL_CYC = `RDH_QUAL_CYC
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata,
  output reg         irqOut,
  // pins from sequencer
  input  wire        retreat_return_req,
  input  wire        gp_output_clear_req,
  input  wire        slot_run_req,
  input  wire        slot_halt_req,
  input  wire        stopReq,
  input  wire        estopIn,
  input  wire        motion_lock_req,
  input  wire        warmup_mode_enable,
  // internal status sources
  input  wire        batteryLow,
  input  wire        severeErr,
  input  wire        minorErr,
  input  wire        warnErr,
  input  wire [7:0]  handIn,
  input  wire [7:0]  zoneHit,
  input  wire        warmupRun,
  // pins toward sequencer
  output reg         retreatActive,
  output reg         gpOutClear,
  output reg         battery_low_flag,
  output reg         severe_error_flag,
  output reg         minor_error_flag,
  output reg         warning_flag,
  output reg         estop_active_flag,
  output reg         slotRunning,
  output reg  [7:0]  gripper_input_state,
  output reg         zone_presence_flag,
  output reg         warmup_active_flag,
  output reg         program_rewind_req,
  output reg         motionLockActive,
  output reg         servoPowerOn
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers, two flops per external pin
  // sequencer pins and hand/zone sensors bear no relation to clk_sys
  localparam NIN = 24;
  wire [NIN-1:0] rawIn;    // packed copy of every asynchronous input
  reg  [NIN-1:0] syncA_q;  // first stage, may go metastable
  reg  [NIN-1:0] syncB_q;  // second stage, the only one logic reads
  reg            armA_q;   // servo arm chain, first step
  reg            armB_q;   // high once the estop sync holds a real sample
  assign rawIn = {zoneHit, handIn, warmup_mode_enable, motion_lock_req,
                  estopIn, stopReq, slot_halt_req, slot_run_req,
                  gp_output_clear_req, retreat_return_req};

  // first stage read only by second stage
  // the arm chain runs beside it, so the servo stays off until the
  // estop pin has really been sampled after reset
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      syncA_q <= {NIN{1'b0}};
      syncB_q <= {NIN{1'b0}};
      armA_q  <= 1'b0;
      armB_q  <= 1'b0;
    end else begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
      armA_q  <= 1'b1;
      armB_q  <= armA_q;
    end
  end

  // named taps of the second stage
  wire       sRetreat = syncB_q[0];
  wire       sGpClr   = syncB_q[1];
  wire       sRun     = syncB_q[2];
  wire       sHalt    = syncB_q[3];
  wire       sStop    = syncB_q[4];
  wire       sEstop   = syncB_q[5];
  wire       sLock    = syncB_q[6];
  wire       sWuEna   = syncB_q[7];
  wire [7:0] sHand    = syncB_q[15:8];
  wire [7:0] sZone    = syncB_q[23:16];

  ////////////////////////////////////////////////////////////////////////////
  // pulse qualifiers; a glitch restarts the count, so short pulses vanish
  // counter width covers the full 30 ms hold at 50 MHz
  localparam CW = 21;
  reg  [CW-1:0] qRet_q;
  reg  [CW-1:0] qClr_q;
  reg  [CW-1:0] qRun_q;

  // saturating counter step
  // clears whenever the level drops, parks at the limit otherwise
  function [CW-1:0] qstep;
    input          lvl;
    input [CW-1:0] cnt;
    begin
      if (!lvl)
        qstep = {CW{1'b0}};
      else if (cnt == QUAL_CYC[CW-1:0])
        qstep = cnt;
      else
        qstep = cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  // one-cycle fire when count first reaches the limit
  // parking at the limit keeps a long hold from firing twice
  function qfire;
    input          lvl;
    input [CW-1:0] cnt;
    begin
      qfire = lvl && (cnt == QUAL_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});
    end
  endfunction

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      qRet_q <= {CW{1'b0}};
      qClr_q <= {CW{1'b0}};
      qRun_q <= {CW{1'b0}};
    end else begin
      qRet_q <= qstep(sRetreat, qRet_q);
      qClr_q <= qstep(sGpClr, qClr_q);
      qRun_q <= qstep(sRun, qRun_q);
    end
  end

  wire retFire = qfire(sRetreat, qRet_q);
  wire clrFire = qfire(sGpClr, qClr_q);
  wire runFire = qfire(sRun, qRun_q);

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  reg  [2:0] ctrl_q;   // done, cancel, rewind
  reg  [3:0] irqStat_q;
  reg  [3:0] irqMask_q;
  wire       wrCtrl = regWr && (regAddr == `RDH_ADDR_CTRL);
  wire       wrStat = regWr && (regAddr == `RDH_ADDR_IRQ_STAT);
  wire       wrMask = regWr && (regAddr == `RDH_ADDR_IRQ_MASK);
  wire       retDone  = wrCtrl && regWdata[`RDH_CTRL_RETDONE];
  wire       wuCancel = wrCtrl && regWdata[`RDH_CTRL_WUCANCEL];
  wire [3:0] events;

  // control bits; done and cancel are self-clearing strobes
  // writes land on the edge that samples the strobe
  // mask resets to zero, so the interrupt line stays quiet until enabled
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q    <= 3'h0;
      irqMask_q <= `RDH_MASK_RST;
    end else begin
      if (wrCtrl)
        ctrl_q <= {regWdata[`RDH_CTRL_REWIND], 2'b00};
      else
        ctrl_q <= {ctrl_q[2], 2'b00};
      if (wrMask)
        irqMask_q <= regWdata[3:0];
    end
  end

  // sticky events; a new event wins over write-one-clear
  // level sources such as the severe error re-set the bit while present
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      irqStat_q <= 4'h0;
    else if (wrStat)
      irqStat_q <= (irqStat_q & ~regWdata[3:0]) | events;
    else
      irqStat_q <= irqStat_q | events;
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake state
  // estop edge detector idles low like its pin
  reg estopDly_q;
  reg warmCut_q;
  assign events = {severeErr, sEstop & ~estopDly_q, clrFire, retFire};

  // outputs registered straight from flops
  // every output low while reset is held
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      retreatActive       <= 1'b0;
      gpOutClear          <= 1'b0;
      battery_low_flag    <= 1'b0;
      severe_error_flag   <= 1'b0;
      minor_error_flag    <= 1'b0;
      warning_flag        <= 1'b0;
      estop_active_flag   <= 1'b0;
      slotRunning         <= 1'b0;
      gripper_input_state <= 8'h00;
      zone_presence_flag  <= 1'b0;
      warmup_active_flag  <= 1'b0;
      program_rewind_req  <= 1'b0;
      motionLockActive    <= 1'b0;
      servoPowerOn        <= 1'b0;
      estopDly_q          <= 1'b0;
      warmCut_q           <= 1'b0;
      irqOut              <= 1'b0;
    end else begin
      estopDly_q <= sEstop;
      // active until done or estop
      // estop beats a fresh retreat request
      if (retFire && !sEstop)
        retreatActive <= 1'b1;
      else if (retDone || sEstop)
        retreatActive <= 1'b0;
      gpOutClear <= clrFire;
      battery_low_flag  <= batteryLow;
      severe_error_flag <= severeErr;
      minor_error_flag  <= minorErr;
      warning_flag      <= warnErr;
      estop_active_flag <= sEstop;
      // stop sources win over start
      // stops are not qualified, so a halt acts within three cycles
      if (sStop || sHalt || sEstop)
        slotRunning <= 1'b0;
      else if (runFire)
        slotRunning <= 1'b1;
      // hand mirror
      // hand and zone outputs trail their pins by three cycles
      gripper_input_state <= sHand;
      zone_presence_flag <= |sZone;
      // cancel latch until enable drops
      // cancel also blanks the flag in its own write cycle
      if (!sWuEna)
        warmCut_q <= 1'b0;
      else if (wuCancel)
        warmCut_q <= 1'b1;
      warmup_active_flag <= sWuEna && warmupRun && !warmCut_q && !wuCancel;
      // rewind level also opens the motion lock gate
      program_rewind_req <= ctrl_q[2];
      motionLockActive <= sLock && ctrl_q[2];
      // hardware servo cut
      // no software path can hold the servo on while estop is seen
      servoPowerOn <= !sEstop && armB_q;
      // interrupt level, one cycle behind the sticky bits
      irqOut <= |(irqStat_q & irqMask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after strobe, unmapped reads zero
  // data drop to zero outside the answer cycle
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      regRdata <= 32'h0000_0000;
    else if (regRd) begin
      case (regAddr)
        `RDH_ADDR_CTRL:     regRdata <= {29'h0, ctrl_q};
        // status word packs ten level outputs for polling, but not rewind or zone presence
        `RDH_ADDR_STATUS:   regRdata <= {22'h0, warmup_active_flag,
                              motionLockActive, slotRunning,
                              estop_active_flag, warning_flag,
                              minor_error_flag, severe_error_flag,
                              battery_low_flag, retreatActive,
                              servoPowerOn};
        `RDH_ADDR_IRQ_STAT: regRdata <= {28'h0, irqStat_q};
        `RDH_ADDR_IRQ_MASK: regRdata <= {28'h0, irqMask_q};
        // raw synchronised area hits
        `RDH_ADDR_ZONE:     regRdata <= {24'h0, sZone};
        default:            regRdata <= 32'h0000_0000;
      endcase
    end else
      regRdata <= 32'h0000_0000;
  end

endmodule
`default_nettype wire
